/* src/hrpc_defs.vh */
`ifndef HRPC_DEFS_VH
`define HRPC_DEFS_VH
`define HRPC_OFS_CTRL 12'h000
`define HRPC_OFS_RTC 12'h004
`define HRPC_OFS_SUBSEC 12'h008
`define HRPC_OFS_MATCH 12'h00c
`define HRPC_OFS_SSMATCH 12'h010
`define HRPC_OFS_MATCHIDX 12'h014
`define HRPC_OFS_IM 12'h018
`define HRPC_OFS_RIS 12'h01c
`define HRPC_OFS_MIS 12'h020
`define HRPC_OFS_ICLR 12'h024
`define HRPC_OFS_STATSEL 12'h028
`define HRPC_OFS_HIBREQ 12'h02c
`define HRPC_CTRL_ACTIVE 0
`define HRPC_CTRL_RTCEN 1
`define HRPC_CTRL_WAKE_RTC 2
`define HRPC_CTRL_WAKE_PIN 3
`define HRPC_CTRL_LS_DET 4
`define HRPC_CTRL_LS_ABORT 5
`define HRPC_CTRL_LVL_LO 6
`define HRPC_CTRL_LVL_HI 7
`define HRPC_CTRL_HIB 8
`define HRPC_EV_WRC 0
`define HRPC_EV_PIN 1
`define HRPC_EV_LOWS 2
`define HRPC_EV_MATCH 3
`define HRPC_EV_VFAIL 4
`define HRPC_EV_RSTW 5
`define HRPC_EV_GPW 6
`define HRPC_NEV 7
`define HRPC_SUBSEC_MAX 15'h7fff
`define HRPC_TICK_DIV_DEFAULT 3052
`endif

/* src/hrpc_sync.v */
`timescale 1ns/10ps
module hrpc_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire reset,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;
    // Two stages: the first is read only by the second
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

/* src/hrpc_top.v */
// Function
// - Status reads as raw flags or mask-qualified flags, chosen by the reader.
// - Reset-pin wake sets both reset-pin and general-pin wake flags.
// - Control register active bit survives processor power-on reset.
// - Low-supply detection enabled and supply low sets low-supply raw flag.
// - Abort option with low supply blocks power removal on hibernate request.
// - Threshold selects one of four levels: 1.9, 2.1, 2.3, 2.5 V.
// - Hibernate request drops regulator enable; block stays powered.
// - While hibernating, any enabled wake condition restores regulator enable.
// - Processor power-on reset does not reset this block.
// - RTC enable cleared stops counting, match events and RTC wake.
// - Seconds counter readable, writable only while enabled, counts once per second.
// - Match sets match flag and may interrupt, wake, or both.
// - Single match comparator at index zero; other indices reserved.
// - Sub-second counter readable, steps of 1/32768 second.
// - Each event source has its own enable bit.
// - Writing a bit mask clears the selected pending flags.
// - Match needs both seconds and sub-second counts equal their match values.
`timescale 1ns/10ps
`include "hrpc_defs.vh"
module hrpc_top #(
    parameter TICK_DIV = `HRPC_TICK_DIV_DEFAULT
) (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire wake_pin_n,
    input wire reset_pin_n,
    input wire [3:0] supply_below,
    input wire supply_fail,
    output reg regulator_en,
    output wire irq
);
    // Synchronised pins; supply_below[i] high means supply below level i
    wire [7:0] pin_s;
    hrpc_sync #(.W(8)) u_sync (
        .clk(clk),
        .reset(reset),
        .d({1'b0, supply_fail, supply_below, ~reset_pin_n, ~wake_pin_n}),
        .q(pin_s)
    );
    wire wake_pin_s = pin_s[0];
    wire rst_pin_s = pin_s[1];
    wire [3:0] below_s = pin_s[5:2];
    wire vfail_s = pin_s[6];

    reg active_reg;
    reg rtc_en_reg;
    reg wake_rtc_reg;
    reg wake_pin_en_reg;
    reg ls_det_reg;
    reg ls_abort_reg;
    reg [1:0] level_reg;
    reg hib_reg;
    reg [31:0] rtc_reg;
    reg [14:0] subsec_reg;
    reg [31:0] match_reg;
    reg [14:0] ssmatch_reg;
    reg [31:0] match_idx_reg;
    reg [`HRPC_NEV-1:0] im_reg;
    reg [`HRPC_NEV-1:0] ris_reg;
    reg stat_sel_reg;
    reg [15:0] div_reg;
    reg rst_pin_d_reg;
    reg wake_pin_d_reg;

    wire wr = psel & penable & pwrite;
    wire rd_ok = psel & ~pwrite;
    wire rtc_wr = wr && paddr == `HRPC_OFS_RTC;
    wire ss_wr = wr && paddr == `HRPC_OFS_SUBSEC;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // One tick every TICK_DIV cycles approximates the 32.768 kHz time source
    wire tick = rtc_en_reg && div_reg == TICK_DIV - 1;
    wire wrap = tick && subsec_reg == `HRPC_SUBSEC_MAX;
    // Comparison only while counting, so a stale match cannot refire when disabled
    wire match_now = rtc_en_reg && rtc_reg == match_reg && subsec_reg == ssmatch_reg;
    reg match_d_reg;
    wire match_ev = match_now & ~match_d_reg;

    wire low_supply = below_s[level_reg];
    wire ls_ev = ls_det_reg & low_supply;
    wire rst_ev = rst_pin_s & ~rst_pin_d_reg;
    wire pin_ev = wake_pin_s & ~wake_pin_d_reg;

    reg [`HRPC_NEV-1:0] set_vec;
    always @* begin
        set_vec = {`HRPC_NEV{1'b0}};
        set_vec[`HRPC_EV_WRC] = rtc_wr & rtc_en_reg;
        set_vec[`HRPC_EV_PIN] = pin_ev;
        set_vec[`HRPC_EV_LOWS] = ls_ev;
        set_vec[`HRPC_EV_MATCH] = match_ev;
        set_vec[`HRPC_EV_VFAIL] = vfail_s;
        set_vec[`HRPC_EV_RSTW] = rst_ev & hib_reg;
        set_vec[`HRPC_EV_GPW] = (rst_ev | pin_ev) & hib_reg;
    end

    wire [`HRPC_NEV-1:0] clr_vec = (wr && paddr == `HRPC_OFS_ICLR) ? pwdata[`HRPC_NEV-1:0] :
        {`HRPC_NEV{1'b0}};
    wire [`HRPC_NEV-1:0] mis = ris_reg & im_reg;
    assign irq = |mis;

    wire wake_cond = (wake_rtc_reg & match_ev) | (wake_pin_en_reg & (pin_ev | rst_ev));

    // Only the always-on reset clears this block; processor reset has no port here
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            active_reg <= 1'b0;
            rtc_en_reg <= 1'b0;
            wake_rtc_reg <= 1'b0;
            wake_pin_en_reg <= 1'b0;
            ls_det_reg <= 1'b0;
            ls_abort_reg <= 1'b0;
            level_reg <= 2'h0;
            hib_reg <= 1'b0;
            regulator_en <= 1'b1;
            rtc_reg <= 32'h0;
            subsec_reg <= 15'h0;
            match_reg <= 32'h0;
            ssmatch_reg <= 15'h0;
            match_idx_reg <= 32'h0;
            im_reg <= {`HRPC_NEV{1'b0}};
            ris_reg <= {`HRPC_NEV{1'b0}};
            stat_sel_reg <= 1'b0;
            div_reg <= 16'h0;
            rst_pin_d_reg <= 1'b0;
            wake_pin_d_reg <= 1'b0;
            match_d_reg <= 1'b0;
        end else begin
            rst_pin_d_reg <= rst_pin_s;
            wake_pin_d_reg <= wake_pin_s;
            match_d_reg <= match_now;
            if (!rtc_en_reg || tick) begin
                div_reg <= 16'h0;
            end else begin
                div_reg <= div_reg + 16'h1;
            end
            // Set wins over a clear in the same cycle
            ris_reg <= (ris_reg & ~clr_vec) | set_vec;
            if (wr) begin
                case (paddr)
                    `HRPC_OFS_CTRL: begin
                        active_reg <= pwdata[`HRPC_CTRL_ACTIVE];
                        rtc_en_reg <= pwdata[`HRPC_CTRL_RTCEN];
                        wake_rtc_reg <= pwdata[`HRPC_CTRL_WAKE_RTC];
                        wake_pin_en_reg <= pwdata[`HRPC_CTRL_WAKE_PIN];
                        ls_det_reg <= pwdata[`HRPC_CTRL_LS_DET] | pwdata[`HRPC_CTRL_LS_ABORT];
                        ls_abort_reg <= pwdata[`HRPC_CTRL_LS_ABORT];
                        level_reg <= pwdata[`HRPC_CTRL_LVL_HI:`HRPC_CTRL_LVL_LO];
                    end
                    `HRPC_OFS_MATCH: begin
                        if (match_idx_reg == 32'h0) begin
                            match_reg <= pwdata;
                        end
                    end
                    `HRPC_OFS_SSMATCH: begin
                        if (match_idx_reg == 32'h0) begin
                            ssmatch_reg <= pwdata[14:0];
                        end
                    end
                    `HRPC_OFS_MATCHIDX: match_idx_reg <= pwdata;
                    `HRPC_OFS_IM: im_reg <= pwdata[`HRPC_NEV-1:0];
                    `HRPC_OFS_STATSEL: stat_sel_reg <= pwdata[0];
                    default: ;
                endcase
            end
            // Software writes to the counters only take effect while running
            if (rtc_wr && rtc_en_reg) begin
                rtc_reg <= pwdata;
            end else if (wrap) begin
                rtc_reg <= rtc_reg + 32'h1;
            end
            if (ss_wr && rtc_en_reg) begin
                subsec_reg <= pwdata[14:0];
            end else if (tick) begin
                subsec_reg <= wrap ? 15'h0 : subsec_reg + 15'h1;
            end
            // Hibernate request: abort leaves power on, software must cope
            if (wr && paddr == `HRPC_OFS_HIBREQ && pwdata[`HRPC_CTRL_HIB] && !hib_reg) begin
                if (!(ls_abort_reg && low_supply)) begin
                    hib_reg <= 1'b1;
                    regulator_en <= 1'b0;
                end
            end else if (hib_reg && wake_cond) begin
                hib_reg <= 1'b0;
                regulator_en <= 1'b1;
            end
        end
    end

    // Read mux; unmapped and reserved match indices read zero
    always @* begin
        prdata = 32'h0;
        if (rd_ok) begin
            case (paddr)
                `HRPC_OFS_CTRL: begin
                    prdata[`HRPC_CTRL_ACTIVE] = active_reg;
                    prdata[`HRPC_CTRL_RTCEN] = rtc_en_reg;
                    prdata[`HRPC_CTRL_WAKE_RTC] = wake_rtc_reg;
                    prdata[`HRPC_CTRL_WAKE_PIN] = wake_pin_en_reg;
                    prdata[`HRPC_CTRL_LS_DET] = ls_det_reg;
                    prdata[`HRPC_CTRL_LS_ABORT] = ls_abort_reg;
                    prdata[`HRPC_CTRL_LVL_HI:`HRPC_CTRL_LVL_LO] = level_reg;
                    prdata[`HRPC_CTRL_HIB] = hib_reg;
                end
                `HRPC_OFS_RTC: prdata = rtc_reg;
                `HRPC_OFS_SUBSEC: prdata = {17'h0, subsec_reg};
                `HRPC_OFS_MATCH: prdata = (match_idx_reg == 32'h0) ? match_reg : 32'h0;
                `HRPC_OFS_SSMATCH: prdata = (match_idx_reg == 32'h0) ? {17'h0, ssmatch_reg} : 32'h0;
                `HRPC_OFS_MATCHIDX: prdata = match_idx_reg;
                `HRPC_OFS_IM: prdata = {25'h0, im_reg};
                `HRPC_OFS_RIS: prdata = {25'h0, stat_sel_reg ? mis : ris_reg};
                `HRPC_OFS_MIS: prdata = {25'h0, mis};
                `HRPC_OFS_STATSEL: prdata = {31'h0, stat_sel_reg};
                default: prdata = 32'h0;
            endcase
        end
    end
endmodule

/* test/hibernation_rtc_power_control_test.sv */
`timescale 1ns/10ps
`include "hrpc_defs.vh"
module hibernation_rtc_power_control_test;
    reg clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pin_req = 0, rst_req = 0, fail_req = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [3:0] low_req = 0;
    wire [31:0] prdata;
    wire pready, pslverr, wake_pin_n, reset_pin_n, supply_fail, regulator_en, irq;
    wire [3:0] supply_below;
    integer error_cnt = 0, checks = 0, i;
    hrpc_top #(.TICK_DIV(2)) hrpc_top_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wake_pin_n, .reset_pin_n, .supply_below, .supply_fail, .regulator_en, .irq);
    hrpc_partner hrpc_partner_inst (.pin_req, .rst_req, .low_req, .fail_req, .wake_pin_n, .reset_pin_n, .supply_below,
        .supply_fail);
    initial begin
        forever #5 clk = ~clk;
    end
    task chk(input string n, input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task xfer(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input string n, input [11:0] a, input [31:0] m, input [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(n, rd & m, e);
    endtask
    task wake(input [1:0] how);
        xfer(1'b1, `HRPC_OFS_ICLR, 32'h7f);
        xfer(1'b1, `HRPC_OFS_HIBREQ, 32'h100);
        @(posedge clk);
        chk("hib", regulator_en, 0);
        {rst_req, pin_req} <= how;
        for (i = 0; i < 20 && regulator_en !== 1'b1; i = i + 1)
            @(posedge clk);
        {rst_req, pin_req} <= 2'b00;
        chk("wake", regulator_en, 1);
    endtask
    task results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        results;
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        chk("reg_en", regulator_en, 1);
        xfer(1'b1, `HRPC_OFS_RTC, 32'h5);
        rdc("rtc_off", `HRPC_OFS_RTC, ~32'h0, 32'h0);
        xfer(1'b1, `HRPC_OFS_CTRL, 32'h0b);
        xfer(1'b1, `HRPC_OFS_RTC, 32'h10);
        rdc("rtc", `HRPC_OFS_RTC, ~32'h0, 32'h10);
        rdc("wr_done", `HRPC_OFS_RIS, 32'h1, 32'h1);
        xfer(1'b1, `HRPC_OFS_SUBSEC, 32'h7ffe);
        repeat (10) @(posedge clk);
        rdc("wrap", `HRPC_OFS_RTC, ~32'h0, 32'h11);
        rdc("subsec", `HRPC_OFS_SUBSEC, 32'hfff0, 32'h0);
        xfer(1'b1, `HRPC_OFS_MATCHIDX, 32'h0);
        xfer(1'b1, `HRPC_OFS_MATCH, 32'h12);
        xfer(1'b1, `HRPC_OFS_SSMATCH, 32'h4000);
        xfer(1'b1, `HRPC_OFS_RTC, 32'h12);
        xfer(1'b1, `HRPC_OFS_ICLR, 32'h7f);
        rdc("sec_only", `HRPC_OFS_RIS, 32'h08, 32'h0);
        xfer(1'b1, `HRPC_OFS_SUBSEC, 32'h3ff0);
        repeat (60) @(posedge clk);
        rdc("match", `HRPC_OFS_RIS, 32'h08, 32'h08);
        xfer(1'b1, `HRPC_OFS_RTC, 32'h13);
        xfer(1'b1, `HRPC_OFS_IM, 32'h08);
        xfer(1'b1, `HRPC_OFS_STATSEL, 32'h1);
        rdc("sel_mask", `HRPC_OFS_RIS, ~32'h0, 32'h08);
        rdc("mis", `HRPC_OFS_MIS, ~32'h0, 32'h08);
        chk("irq_on", irq, 1);
        xfer(1'b1, `HRPC_OFS_STATSEL, 32'h0);
        rdc("raw", `HRPC_OFS_RIS, 32'h09, 32'h09);
        xfer(1'b1, `HRPC_OFS_ICLR, 32'h7f);
        rdc("clr", `HRPC_OFS_RIS, ~32'h0, 32'h0);
        chk("irq_off", irq, 0);
        xfer(1'b1, `HRPC_OFS_IM, 32'h0);
        xfer(1'b1, `HRPC_OFS_MATCHIDX, 32'h1);
        rdc("idx", `HRPC_OFS_MATCH, ~32'h0, 32'h0);
        xfer(1'b1, `HRPC_OFS_MATCHIDX, 32'h0);
        wake(2'b10);
        rdc("rst_wake", `HRPC_OFS_RIS, 32'h60, 32'h60);
        rdc("active", `HRPC_OFS_CTRL, 32'h1, 32'h1);
        rdc("rtc_kept", `HRPC_OFS_RTC, ~32'h0, 32'h13);
        wake(2'b01);
        rdc("pin_wake", `HRPC_OFS_RIS, 32'h02, 32'h02);
        low_req <= 4'b1100;
        for (i = 0; i < 4; i = i + 1) begin
            xfer(1'b1, `HRPC_OFS_CTRL, 32'h13 | (i << 6));
            xfer(1'b1, `HRPC_OFS_ICLR, 32'h7f);
            repeat (5) @(posedge clk);
            rdc("low", `HRPC_OFS_RIS, 32'h04, (i > 1) ? 32'h04 : 32'h0);
        end
        xfer(1'b1, `HRPC_OFS_CTRL, 32'he3);
        xfer(1'b1, `HRPC_OFS_HIBREQ, 32'h100);
        @(posedge clk);
        chk("abort", regulator_en, 1);
        fail_req <= 1'b1;
        repeat (5) @(posedge clk);
        rdc("vfail", `HRPC_OFS_RIS, 32'h10, 32'h10);
        fail_req <= 1'b0;
        results;
    end
endmodule

/* test/hrpc_partner.sv */
`timescale 1ns/10ps
module hrpc_partner (
    input wire pin_req,
    input wire rst_req,
    input wire [3:0] low_req,
    input wire fail_req,
    output wire wake_pin_n,
    output wire reset_pin_n,
    output wire [3:0] supply_below,
    output wire supply_fail
);
    // Pins are pulled up, so idle reads high
    assign wake_pin_n = !pin_req;
    assign reset_pin_n = !rst_req;
    assign supply_below = low_req;
    assign supply_fail = fail_req;
endmodule

/* test/hrpc_sva.sv */
`timescale 1ns/10ps
`include "hrpc_defs.vh"
module hrpc_sva (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [3:0] supply_below,
    input wire regulator_en,
    input wire irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    wire wr = psel && penable && pwrite;
    wire hib = wr && paddr == `HRPC_OFS_HIBREQ && pwdata[8];
    a_ready_high: assert property (psel && penable |-> pready && !pslverr) else $error("no ready");
    a_write_quiet: assert property (psel && pwrite |-> prdata == 32'h0) else $error("prdata on write");
    a_unmapped_zero: assert property (psel && !pwrite && paddr > 12'h02f |-> prdata == 32'h0)
        else $error("unmapped data");
    // Supply history checked too, since detection lags the pin by the synchroniser
    a_hib_drop: assert property (hib && supply_below == 4'h0 && $past(supply_below, 2) == 4'h0 |=> !regulator_en)
        else $error("power kept");
    a_fall_cause: assert property ($fell(regulator_en) |-> $past(hib)) else $error("power dropped");
    a_mask_irq: assert property (wr && paddr == `HRPC_OFS_IM && pwdata == 32'h0 |=> !irq)
        else $error("irq unmasked");
    a_reset_keep: assert property ($fell(reset) |-> regulator_en && !irq) else $error("bad reset");
    // Hibernating bit and regulator enable must always move together
    a_hib_state: assert property (psel && !pwrite && paddr == `HRPC_OFS_CTRL |-> prdata[8] == !regulator_en)
        else $error("hib state");
endmodule
bind hrpc_top hrpc_sva hrpc_sva_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .supply_below, .regulator_en, .irq);
